// File: hdl/can_filter_fifo_ptr.v
// can filter control, devicenet compare count and per-fifo pointer read-back
// assumes a single 10 MHz clock, synchronous reset and a register master that
// never issues read and write strobes together
//
// Functional notes
// - halt operation in idle when bit set
// - active flag reads one until fully disabled
// - five-bit devicenet compare count, high values invalid
// - per-filter enable bits at 15 and 7
// - two-bit mask select picks mask 0-3
// - five-bit fifo select names target fifo
// - selects writable only while filter disabled
// - transmit fifo user address is head
// - receive fifo user address is tail
// - user address low two bits zero
// - transmit index is next message sent
// - receive index is next slot stored
// - control bits 12 and 10-5 zero
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "can_regs_map.vh"

// ----------------------------------------------------------------
// small match queue
// ----------------------------------------------------------------
module match_queue #(
  parameter WIDTH = 7,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             mclk_i,    // system clock
  input  wire             rst_i,     // synchronous reset, active high
  input  wire             in_valid_i, // push request
  output wire             in_ready_o, // space available
  input  wire [WIDTH-1:0] in_data_i,  // pushed word
  output wire             out_valid_i_n, // unused name guard
  output wire             out_valid_o, // word available
  input  wire             out_ready_i, // pop request
  output wire [WIDTH-1:0] out_data_o   // head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg             full_reg;
  reg             empty_reg;
  wire            push;
  wire            pop;
  reg  [AW:0]     count_next;

  assign push          = in_valid_i & ~full_reg;
  assign pop           = out_ready_i & ~empty_reg;
  assign in_ready_o    = ~full_reg;
  assign out_valid_o   = ~empty_reg;
  assign out_valid_i_n = empty_reg;
  assign out_data_o    = mem[rd_ptr_reg];

  always @* begin
    count_next = count_reg;
    if (push & ~pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop & ~push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      full_reg   <= 1'b0;
      empty_reg  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH-1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH-1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      full_reg  <= (count_next == DEPTH);
      empty_reg <= (count_next == {(AW+1){1'b0}});
    end
  end
endmodule

// ----------------------------------------------------------------
// top: registers, filter path and pointer bank
// ----------------------------------------------------------------
module can_filter_fifo_ptr #(
  parameter        NFIFO     = 32,
  parameter        MSG_BYTES = `MSG_BYTES_DEFAULT,
  parameter [31:0] MSG_BASE  = `MSG_BASE_DEFAULT,
  parameter        QDEPTH    = 4
) (
  input  wire        mclk_i,          // system clock, 10 MHz
  input  wire        rst_i,           // synchronous reset, active high
  input  wire [9:0]  addr_i,          // register byte address
  input  wire [31:0] wdata_i,         // write data
  input  wire        wr_i,            // write strobe, one cycle
  input  wire        rd_i,            // read strobe, one cycle
  output reg  [31:0] rdata_o,         // read data, cycle after rd_i
  input  wire        sys_idle_i,      // system is in idle mode
  input  wire        match_valid_i,   // acceptance hit offered
  input  wire        match_filter_i,  // 0 filter 12, 1 filter 13
  output reg         match_ready_o,   // queue had space on the previous cycle
  input  wire        tx_sent_i,       // can side finished one transmit
  input  wire [4:0]  tx_fifo_i,       // fifo of that transmit
  output reg         store_valid_o,   // one-cycle pulse: message stored
  output reg  [4:0]  store_fifo_o,    // fifo that took the message
  output reg  [1:0]  store_mask_o,    // acceptance mask that was used
  output reg  [4:0]  dn_compare_bits_o, // devicenet data bits compared
  output reg         running_o        // can engine is running
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg        enable_reg;
  reg        halt_idle_reg;
  reg        active_reg;
  reg [4:0]  devicenet_compare_bit_count_reg;
  reg        en13_reg;
  reg [1:0]  filter_13_mask_select_reg;
  reg [4:0]  filter_13_fifo_select_reg;
  reg        en12_reg;
  reg [1:0]  filter_12_mask_select_reg;
  reg [4:0]  filter_12_fifo_select_reg;
  reg [31:0] dir_reg;
  reg [4:0]  user_idx_reg [0:NFIFO-1];
  reg [4:0]  can_idx_reg  [0:NFIFO-1];
  reg [31:0] read_word;
  integer    i;

  wire [4:0] win_fifo;
  wire       win_hit;
  wire       win_ci;
  wire       wr_ctl;
  wire       wr_flt;
  wire       wr_dir;
  wire       wr_adv;
  wire       run;
  wire       q_in_ready;
  wire       q_out_valid;
  wire [6:0] q_out_data;
  wire       q_pop;
  wire       q_push;
  wire [6:0] q_in_data;
  wire [4:0] pop_fifo;
  wire       pop_rx;
  wire       sel_ctl;
  wire       sel_flt;
  wire       sel_dir;
  wire       sel_adv;

  // one comparator shared by the write strobes and the read mux, so a
  // register can never answer reads at one offset and writes at another
  function at_offset;
    input [9:0] a;
    input [9:0] ofs;
    begin
      at_offset = (a == ofs);
    end
  endfunction

  assign win_hit  = (addr_i >= `OFS_FIFO_WINDOW) && (addr_i <= `FIFO_WINDOW_TOP);
  assign win_fifo = addr_i[7:3];
  assign win_ci   = addr_i[2];
  assign sel_ctl  = at_offset(addr_i, `OFS_MODULE_CONTROL);
  assign sel_flt  = at_offset(addr_i, `OFS_FILTER_CONTROL_3);
  assign sel_dir  = at_offset(addr_i, `OFS_FIFO_DIRECTION);
  assign sel_adv  = at_offset(addr_i, `OFS_USER_ADVANCE);
  assign wr_ctl   = wr_i && sel_ctl;
  assign wr_flt   = wr_i && sel_flt;
  assign wr_dir   = wr_i && sel_dir;
  assign wr_adv   = wr_i && sel_adv;

  assign run = enable_reg & ~(halt_idle_reg & sys_idle_i);

  // message address of one slot; low bits stay clear for any word-multiple size
  function [31:0] slot_addr;
    input [4:0] fifo;
    input [4:0] idx;
    begin
      slot_addr = MSG_BASE + ({22'h000000, fifo, idx} * MSG_BYTES);
      slot_addr[1:0] = 2'h0;
    end
  endfunction

  // indexes wrap at 32 slots, the width of the index field
  function [4:0] next_idx;
    input [4:0] idx;
    begin
      next_idx = idx + 5'h01;
    end
  endfunction

  // ----------------------------------------------------------------
  // match path through the queue
  // ----------------------------------------------------------------
  // disabled filter drops hit
  assign q_push    = match_valid_i & run &
                     (match_filter_i ? en13_reg : en12_reg);
  assign q_in_data = match_filter_i ? {filter_13_mask_select_reg, filter_13_fifo_select_reg} : {filter_12_mask_select_reg, filter_12_fifo_select_reg};
  // draining stalls while halted, and no hits are pushed then, so the queue holds as it is;
  // once disabled the leftovers are dropped, else the active flag never falls
  assign q_pop     = q_out_valid & (run | ~enable_reg);
  assign pop_fifo  = q_out_data[4:0];
  assign pop_rx    = q_out_valid & run & ~dir_reg[pop_fifo];

  match_queue #(
    .WIDTH (7),
    .DEPTH (QDEPTH),
    .AW    (2)
  ) u_queue (
    .mclk_i        (mclk_i),
    .rst_i         (rst_i),
    .in_valid_i    (q_push),
    .in_ready_o    (q_in_ready),
    .in_data_i     (q_in_data),
    .out_valid_i_n (),
    .out_valid_o   (q_out_valid),
    .out_ready_i   (q_pop),
    .out_data_o    (q_out_data)
  );

  // ----------------------------------------------------------------
  // control and filter registers
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      enable_reg    <= 1'b0;
      halt_idle_reg <= 1'b0;
      devicenet_compare_bit_count_reg     <= 5'h00;
      en13_reg      <= 1'b0;
      filter_13_mask_select_reg    <= 2'h0;
      filter_13_fifo_select_reg    <= 5'h00;
      en12_reg      <= 1'b0;
      filter_12_mask_select_reg    <= 2'h0;
      filter_12_fifo_select_reg    <= 5'h00;
      dir_reg       <= `FIFO_DIRECTION_RST;
    end else begin
      if (wr_ctl) begin
        enable_reg    <= wdata_i[`MC_ENABLE_BIT];
        halt_idle_reg <= wdata_i[`MC_HALT_IDLE_BIT];
        devicenet_compare_bit_count_reg     <= wdata_i[`MC_DEVICENET_COMPARE_BIT_COUNT_MSB:`MC_DEVICENET_COMPARE_BIT_COUNT_LSB];
      end
      if (wr_flt) begin
        en13_reg <= wdata_i[`FC_EN13_BIT];
        en12_reg <= wdata_i[`FC_EN12_BIT];
        if (!en13_reg) begin
          filter_13_mask_select_reg <= wdata_i[`FC_FILTER_13_MASK_SELECT_MSB:`FC_FILTER_13_MASK_SELECT_LSB];
          filter_13_fifo_select_reg <= wdata_i[`FC_FILTER_13_FIFO_SELECT_MSB:`FC_FILTER_13_FIFO_SELECT_LSB];
        end
        if (!en12_reg) begin
          filter_12_mask_select_reg <= wdata_i[`FC_FILTER_12_MASK_SELECT_MSB:`FC_FILTER_12_MASK_SELECT_LSB];
          filter_12_fifo_select_reg <= wdata_i[`FC_FILTER_12_FIFO_SELECT_MSB:`FC_FILTER_12_FIFO_SELECT_LSB];
        end
      end
      if (wr_dir) begin
        dir_reg <= wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // pointer bank
  // ----------------------------------------------------------------
  // user side: head of a transmit fifo, tail of a receive fifo
  // can side: next slot sent for transmit, next slot stored for receive
  always @(posedge mclk_i) begin
    if (rst_i) begin
      for (i = 0; i < NFIFO; i = i + 1) begin
        user_idx_reg[i] <= 5'h00;
        can_idx_reg[i]  <= 5'h00;
      end
    end else begin
      for (i = 0; i < NFIFO; i = i + 1) begin
        if (wr_adv && (wdata_i[4:0] == i)) begin
          user_idx_reg[i] <= next_idx(user_idx_reg[i]);
        end
        if (pop_rx && (pop_fifo == i)) begin
          can_idx_reg[i] <= next_idx(can_idx_reg[i]);
        end
        if (tx_sent_i && run && dir_reg[i] && (tx_fifo_i == i)) begin
          can_idx_reg[i] <= next_idx(can_idx_reg[i]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status and outputs
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      active_reg        <= 1'b0;
      match_ready_o     <= 1'b0;
      store_valid_o     <= 1'b0;
      store_fifo_o      <= 5'h00;
      store_mask_o      <= 2'h0;
      dn_compare_bits_o <= 5'h00;
      running_o         <= 1'b0;
    end else begin
      active_reg    <= enable_reg | q_out_valid;
      match_ready_o <= q_in_ready;
      store_valid_o <= pop_rx;
      if (pop_rx) begin
        store_fifo_o <= pop_fifo;
        store_mask_o <= q_out_data[6:5];
      end
      // invalid codes clamp to full count
      dn_compare_bits_o <= (devicenet_compare_bit_count_reg > `DEVICENET_COMPARE_BIT_COUNT_MAX_VALID) ? `DEVICENET_COMPARE_BIT_COUNT_MAX_VALID : devicenet_compare_bit_count_reg;
      running_o         <= run;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // the word is built combinationally and registered once, so rdata_o
  // stays a plain flip-flop output that holds between reads
  always @* begin
    read_word = 32'h00000000;
    if (sel_ctl) begin
      read_word[`MC_ENABLE_BIT]              = enable_reg;
      read_word[`MC_HALT_IDLE_BIT]           = halt_idle_reg;
      read_word[`MC_ACTIVE_BIT]              = active_reg;
      read_word[`MC_DEVICENET_COMPARE_BIT_COUNT_MSB:`MC_DEVICENET_COMPARE_BIT_COUNT_LSB] = devicenet_compare_bit_count_reg;
    end else if (sel_flt) begin
      read_word[15:0] = {en13_reg, filter_13_mask_select_reg, filter_13_fifo_select_reg,
                         en12_reg, filter_12_mask_select_reg, filter_12_fifo_select_reg};
    end else if (sel_dir) begin
      read_word = dir_reg;
    end else if (win_hit && win_ci) begin
      read_word[4:0] = can_idx_reg[win_fifo];
    end else if (win_hit) begin
      read_word = slot_addr(win_fifo, user_idx_reg[win_fifo]);
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      rdata_o <= read_word;
    end
  end
endmodule
`default_nettype wire

// File: hdl/can_regs_map.vh
// register offsets, field positions and reset values of the can filter and fifo pointer block
// included by the design file; holds definitions only
`ifndef CAN_REGS_MAP_VH
`define CAN_REGS_MAP_VH

// byte offsets on the register port
`define OFS_MODULE_CONTROL   10'h000
`define OFS_FILTER_CONTROL_3 10'h004
`define OFS_FIFO_DIRECTION   10'h008
`define OFS_USER_ADVANCE     10'h00C
`define OFS_FIFO_WINDOW      10'h100
`define FIFO_WINDOW_TOP      10'h1FF

// module_control fields
`define MC_ENABLE_BIT        15
`define MC_HALT_IDLE_BIT     13
`define MC_ACTIVE_BIT        11
`define MC_DEVICENET_COMPARE_BIT_COUNT_MSB         4
`define MC_DEVICENET_COMPARE_BIT_COUNT_LSB         0

// filter_control_3 fields
`define FC_EN13_BIT          15
`define FC_FILTER_13_MASK_SELECT_MSB        14
`define FC_FILTER_13_MASK_SELECT_LSB        13
`define FC_FILTER_13_FIFO_SELECT_MSB        12
`define FC_FILTER_13_FIFO_SELECT_LSB        8
`define FC_EN12_BIT          7
`define FC_FILTER_12_MASK_SELECT_MSB        6
`define FC_FILTER_12_MASK_SELECT_LSB        5
`define FC_FILTER_12_FIFO_SELECT_MSB        4
`define FC_FILTER_12_FIFO_SELECT_LSB        0

// devicenet compare count limits
`define DEVICENET_COMPARE_BIT_COUNT_MAX_VALID      5'h12

// reset values
`define MODULE_CONTROL_RST   32'h00000000
`define FILTER_CONTROL_RST   32'h00000000
`define FIFO_DIRECTION_RST   32'h00000000

// fifo message storage
`define MSG_BYTES_DEFAULT    16
`define MSG_BASE_DEFAULT     32'h00000000

`endif

// File: tb/can_bus_node.sv
// far-side model: offers filter hits and reports finished transmits
// assumes the bench calls its tasks; all changes land after a rising edge
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
  input  wire logic       mclk_i,          // system clock
  output var  logic       match_valid_o,   // hit offered
  output var  logic       match_filter_o,  // hit filter
  output var  logic       tx_sent_o,       // transmit done
  output var  logic [4:0] tx_fifo_o        // transmit fifo
);
  initial begin
    match_valid_o = 1'b0;
    match_filter_o = 1'b1;
    tx_sent_o = 1'b0;
    tx_fifo_o = 5'h1F;
  end
  // one hit per cycle; released lines flip so stale values are not trusted
  task hit(input logic f, input int n);
    @(posedge mclk_i);
    match_valid_o <= 1'b1;
    match_filter_o <= f;
    repeat (n) @(posedge mclk_i);
    match_valid_o <= 1'b0;
    match_filter_o <= ~f;
  endtask
  task send(input logic [4:0] q);
    @(posedge mclk_i);
    tx_sent_o <= 1'b1;
    tx_fifo_o <= q;
    @(posedge mclk_i);
    tx_sent_o <= 1'b0;
    tx_fifo_o <= ~q;
  endtask
endmodule
`default_nettype wire

// File: tb/can_filter_fifo_ptr_asserts.sv
// port checker for the can filter and fifo pointer block
// assumes one clock and a sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module can_ffp_checker (
  input wire logic        mclk_i,            // clock
  input wire logic        rst_i,             // reset
  input wire logic [9:0]  addr_i,            // address
  input wire logic        rd_i,              // read strobe
  input wire logic [31:0] rdata_o,           // read data
  input wire logic        running_o,         // engine runs
  input wire logic        store_valid_o,     // store pulse
  input wire logic [4:0]  dn_compare_bits_o  // compare count
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_ctrl_zero;
    rd_i && addr_i == 10'h000 |=> rdata_o[12] == 1'b0 && rdata_o[10:5] == 6'h00;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control spare bits set");
  property p_active;
    rd_i && addr_i == 10'h000 && running_o |=> rdata_o[11];
  endproperty
  a_active: assert property (p_active) else $error("active flag low while running");
  property p_idx_hi;
    rd_i && addr_i[9:8] == 2'b01 && addr_i[2] |=> rdata_o[31:5] == 27'h0;
  endproperty
  a_idx_hi: assert property (p_idx_hi) else $error("index upper bits set");
  property p_align;
    rd_i && addr_i[9:8] == 2'b01 && !addr_i[2] |=> rdata_o[1:0] == 2'b00;
  endproperty
  a_align: assert property (p_align) else $error("user address unaligned");
  property p_dn_max;
    dn_compare_bits_o <= 5'h12;
  endproperty
  a_dn_max: assert property (p_dn_max) else $error("compare count above limit");
  property p_store_run;
    store_valid_o |-> running_o;
  endproperty
  a_store_run: assert property (p_store_run) else $error("store while halted");
  property p_store_gap;
    !running_o [*3] |-> !store_valid_o;
  endproperty
  a_store_gap: assert property (p_store_gap) else $error("store long after halt");
  property p_unmapped;
    rd_i && addr_i == 10'h010 |=> rdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind can_filter_fifo_ptr can_ffp_checker u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .running_o(running_o),
  .store_valid_o(store_valid_o), .dn_compare_bits_o(dn_compare_bits_o));
`default_nettype wire

// File: tb/test_can_filter_fifo_ptr.sv
// register-level bench for the can filter and fifo pointer block
// assumes the checker is bound and the far-side model sits beside it
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_can_filter_fifo_ptr;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        sys_idle_i = 1'b0;
  logic [9:0]  addr_i = 10'h000;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] got;
  logic [4:0]  dn [5] = '{5'h00, 5'h01, 5'h12, 5'h13, 5'h1F};
  wire  [31:0] rdata_o;
  wire  [4:0]  tx_fifo, store_fifo, dn_bits;
  wire  [1:0]  store_mask;
  wire         mvalid, mfilter, tx_sent, store_valid, running, mready;
  int          miscompares = 0;
  int          checked = 0;
  int          stores = 0;
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (store_valid === 1'b1) stores++;
  can_bus_node node (.mclk_i(mclk_i), .match_valid_o(mvalid), .match_filter_o(mfilter),
    .tx_sent_o(tx_sent), .tx_fifo_o(tx_fifo));
  can_filter_fifo_ptr DUT (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sys_idle_i(sys_idle_i), .match_valid_i(mvalid), .match_filter_i(mfilter),
    .match_ready_o(mready), .tx_sent_i(tx_sent), .tx_fifo_i(tx_fifo),
    .store_valid_o(store_valid), .store_fifo_o(store_fifo), .store_mask_o(store_mask),
    .dn_compare_bits_o(dn_bits), .running_o(running));
  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [9:0] a, input logic [31:0] e, input bit c = 1'b1);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
    if (c) `CHK(got, e)
  endtask
  task print_verdict;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(10'h000, 32'h0);
    rd(10'h010, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(10'h000, 32'hA000 | dn[i]);
      repeat (2) @(posedge mclk_i);
      rd(10'h000, 32'hA800 | dn[i]);
      `CHK(dn_bits, (dn[i] > 5'h12) ? 5'h12 : dn[i])
    end
    wr(10'h004, 32'h4723);
    rd(10'h004, 32'h4723);
    wr(10'h004, 32'hC7A3);
    wr(10'h004, 32'hFFFF);
    rd(10'h004, 32'hC7A3);
    wr(10'h004, 32'h0000);
    rd(10'h004, 32'h4723);
    wr(10'h004, 32'hA5C9);
    wr(10'h008, 32'h20);
    rd(10'h008, 32'h20);
    node.hit(1'b0, 1);
    repeat (3) @(posedge mclk_i);
    `CHK(store_fifo, 5'd9)
    `CHK(store_mask, 2'd2)
    `CHK(mready, 1'b1)
    node.hit(1'b1, 1);
    repeat (3) @(posedge mclk_i);
    `CHK(stores, 1)
    rd(10'h14C, 32'h1);
    rd(10'h148, 32'h1200);
    wr(10'h00C, 32'h9);
    rd(10'h148, 32'h1210);
    node.send(5'd5);
    rd(10'h12C, 32'h1);
    rd(10'h128, 32'h0A00);
    wr(10'h00C, 32'h5);
    rd(10'h128, 32'h0A10);
    node.hit(1'b0, 5);
    repeat (4) @(posedge mclk_i);
    `CHK(stores, 6)
    rd(10'h14C, 32'h6);
    @(posedge mclk_i) sys_idle_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    `CHK(running, 1'b0)
    rd(10'h000, 32'hA81F);
    node.hit(1'b0, 2);
    node.send(5'd5);
    repeat (3) @(posedge mclk_i);
    `CHK(stores, 6)
    rd(10'h12C, 32'h1);
    wr(10'h000, 32'h8000);
    repeat (2) @(posedge mclk_i);
    `CHK(running, 1'b1)
    node.send(5'd5);
    rd(10'h12C, 32'h2);
    wr(10'h000, 32'h0);
    for (int i = 0; i < 16; i++) begin
      rd(10'h000, 32'h0, 1'b0);
      if (got[11] === 1'b0) break;
    end
    rd(10'h000, 32'h0);
    print_verdict;
  end
endmodule
`default_nettype wire
